/* hdl/cts_can_tx_cancel_debug_state.sv */
// Transmit cancellation and debug message state logic with APB registers
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module cts_can_tx_cancel_debug_state #(
    parameter int unsigned NUM_BUF = 4
) (
    input  wire logic                       i_core_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_psel,
    input  wire logic                       i_penable,
    input  wire logic                       i_pwrite,
    input  wire logic [7:0]                 i_paddr,
    input  wire logic [31:0]                i_pwdata,
    output logic      [31:0]                o_prdata,
    output logic                            o_pready,
    output logic                            o_pslverr,
    input  wire logic                       i_tx_done,
    input  wire logic                       i_tx_fail,
    input  wire logic                       i_bus_off,
    input  wire logic                       i_dbg_msg,
    input  wire logic [1:0]                 i_dbg_kind,
    output logic                            o_tx_start,
    output logic      [$clog2(NUM_BUF)-1:0] o_tx_buf,
    output logic                            o_irq
);
    localparam int unsigned BW = $clog2(NUM_BUF);

    logic                     init;
    logic                     cce;
    logic                     nar;
    logic [1:0]               debug_msg_state;
    logic [NUM_BUF-1:0]       pending;
    logic [NUM_BUF-1:0]       creq;
    logic [NUM_BUF-1:0]       sent;
    logic [NUM_BUF-1:0]       cdone;
    logic [cts_pkg::IRQ_W-1:0] irq_status;
    logic [cts_pkg::IRQ_W-1:0] irq_en;
    logic                     bus_off_q;
    logic [BW-1:0]            cur;
    cts_pkg::cts_tx_state_t   tx_state;

    function automatic logic [BW-1:0] lowest(input logic [NUM_BUF-1:0] v);
        logic [BW-1:0] idx;
        idx = '0;
        for (int i = NUM_BUF - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = BW'(i);
            end
        end
        return idx;
    endfunction : lowest

    // Bus decode
    wire acc      = i_psel & i_penable;
    wire wr_fire  = acc & o_pready & i_pwrite;
    wire hit_ctrl = i_paddr == cts_pkg::OFS_CORE_CONTROL;
    wire hit_rxq  = i_paddr == cts_pkg::OFS_RXQ1_STATUS;
    wire hit_pend = i_paddr == cts_pkg::OFS_TX_PENDING;
    wire hit_add  = i_paddr == cts_pkg::OFS_TX_ADD_REQ;
    wire hit_canc = i_paddr == cts_pkg::OFS_TX_CANCEL;
    wire hit_sent = i_paddr == cts_pkg::OFS_TX_SENT;
    wire hit_cdn  = i_paddr == cts_pkg::OFS_TX_CDONE;
    wire hit_ist  = i_paddr == cts_pkg::OFS_IRQ_STATUS;
    wire hit_icl  = i_paddr == cts_pkg::OFS_IRQ_CLEAR;
    wire hit_ien  = i_paddr == cts_pkg::OFS_IRQ_ENABLE;
    wire mapped   = hit_ctrl | hit_rxq | hit_pend | hit_add | hit_canc |
                    hit_sent | hit_cdn | hit_ist | hit_icl | hit_ien;
    wire wr_ctrl  = wr_fire & hit_ctrl;
    wire wr_init1 = wr_ctrl & i_pwdata[cts_pkg::CTRL_INIT_BIT];

    wire [31:0] ctrl_rd = {29'h0, nar, cce, init};
    wire [31:0] rd_mux  =
        hit_ctrl ? ctrl_rd :
        hit_rxq  ? {30'h0, debug_msg_state} :
        hit_pend ? {{(32-NUM_BUF){1'b0}}, pending} :
        hit_canc ? {{(32-NUM_BUF){1'b0}}, creq} :
        hit_sent ? {{(32-NUM_BUF){1'b0}}, sent} :
        hit_cdn  ? {{(32-NUM_BUF){1'b0}}, cdone} :
        hit_ist  ? {{(32-cts_pkg::IRQ_W){1'b0}}, irq_status} :
        hit_ien  ? {{(32-cts_pkg::IRQ_W){1'b0}}, irq_en} : 32'h0000_0000;

    // Transmit bookkeeping
    wire                active   = tx_state == cts_pkg::TX_ACTIVE;
    wire [NUM_BUF-1:0]  act_vec  = active ? (NUM_BUF'(1) << cur) : '0;
    wire [NUM_BUF-1:0]  add_vec  = (wr_fire & hit_add) ?
                                   i_pwdata[NUM_BUF-1:0] & ~pending : '0;
    wire [NUM_BUF-1:0]  cwr_vec  = (wr_fire & hit_canc) ?
                                   i_pwdata[NUM_BUF-1:0] & pending : '0;
    wire [NUM_BUF-1:0]  ok_vec   = i_tx_done ? act_vec : '0;
    wire [NUM_BUF-1:0]  fail_vec = (i_tx_fail & ~i_tx_done) ? act_vec : '0;
    wire [NUM_BUF-1:0]  stop_vec = fail_vec & (creq | {NUM_BUF{nar}});
    // Idle buffers cancel at once; the running one only after it fails
    wire [NUM_BUF-1:0]  cdn_vec  = (fail_vec & creq) |
                                   (creq & pending & ~act_vec);
    wire                retry    = |fail_vec & ~|stop_vec;
    wire [NUM_BUF-1:0]  elig     = pending & ~creq & ~cwr_vec;
    wire                start    = ~active & ~init & |elig;
    wire [BW-1:0]       pick     = lowest(elig);
    wire [NUM_BUF-1:0]  next_pending = (pending & ~(ok_vec | stop_vec |
                                        cdn_vec)) | add_vec;
    wire [NUM_BUF-1:0]  next_sent    = (sent & ~add_vec) | ok_vec;
    wire [NUM_BUF-1:0]  next_cdone   = (cdone & ~add_vec) | cdn_vec;
    wire [NUM_BUF-1:0]  next_creq    = (creq | cwr_vec) & next_pending;

    // Debug message state
    wire dbg_reset = wr_init1 | (i_bus_off & ~bus_off_q);
    wire dbg_take  = i_dbg_msg & ~init;
    wire [1:0] dbg_seq =
        (debug_msg_state == cts_pkg::DMS_IDLE && i_dbg_kind == cts_pkg::DBG_KIND_A) ?
            cts_pkg::DMS_ONE :
        (debug_msg_state == cts_pkg::DMS_ONE && i_dbg_kind == cts_pkg::DBG_KIND_B) ?
            cts_pkg::DMS_TWO :
        (i_dbg_kind == cts_pkg::DBG_KIND_A) ? cts_pkg::DMS_ONE :
            cts_pkg::DMS_IDLE;
    // Only the message path and resets move it, never config enable
    wire [1:0] next_dms = dbg_reset ? cts_pkg::DMS_IDLE :
                          dbg_take  ? dbg_seq : debug_msg_state;
    wire next_init = wr_ctrl ? i_pwdata[cts_pkg::CTRL_INIT_BIT] :
                     (init | (i_bus_off & ~bus_off_q));

    // Sticky events; a new event beats a clear in the same cycle
    wire [cts_pkg::IRQ_W-1:0] ev_vec;
    assign ev_vec[cts_pkg::IRQ_SENT]   = |ok_vec;
    assign ev_vec[cts_pkg::IRQ_CANCEL] = |cdn_vec;
    assign ev_vec[cts_pkg::IRQ_DBG]    = next_dms != debug_msg_state;
    wire [cts_pkg::IRQ_W-1:0] clr_vec  = (wr_fire & hit_icl) ?
                                i_pwdata[cts_pkg::IRQ_W-1:0] : '0;
    wire [cts_pkg::IRQ_W-1:0] next_irq = (irq_status & ~clr_vec) | ev_vec;
    wire [cts_pkg::IRQ_W-1:0] clr_only = clr_vec & ~ev_vec;
    // Line follows an enable write at once, not a cycle late
    wire [cts_pkg::IRQ_W-1:0] next_ien = (wr_fire & hit_ien) ?
                                i_pwdata[cts_pkg::IRQ_W-1:0] : irq_en;

    // Answer one cycle into the access phase
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            o_pready  <= acc & ~o_pready;
            o_pslverr <= acc & ~o_pready & ~mapped;
            o_prdata  <= (acc & ~o_pready & ~i_pwrite) ? rd_mux : o_prdata;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            init      <= cts_pkg::INIT_RESET;
            cce       <= cts_pkg::CCE_RESET;
            nar       <= cts_pkg::NAR_RESET;
            bus_off_q <= 1'b0;
            debug_msg_state       <= cts_pkg::DMS_IDLE;
        end else begin
            init      <= next_init;
            cce       <= wr_ctrl ? i_pwdata[cts_pkg::CTRL_CCE_BIT] : cce;
            nar       <= wr_ctrl ? i_pwdata[cts_pkg::CTRL_NAR_BIT] : nar;
            bus_off_q <= i_bus_off;
            debug_msg_state       <= next_dms;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            pending <= '0;
            creq    <= '0;
            sent    <= '0;
            cdone   <= '0;
        end else begin
            pending <= next_pending;
            creq    <= next_creq;
            sent    <= next_sent;
            cdone   <= next_cdone;
        end
    end

    // Frame sequencer; a frame once started always runs to its end
    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_state   <= cts_pkg::TX_IDLE;
            cur        <= '0;
            o_tx_start <= 1'b0;
            o_tx_buf   <= '0;
        end else begin
            o_tx_start <= start | retry;
            unique case (tx_state)
                cts_pkg::TX_IDLE: begin
                    if (start) begin
                        tx_state <= cts_pkg::TX_ACTIVE;
                        cur      <= pick;
                        o_tx_buf <= pick;
                    end
                end
                cts_pkg::TX_ACTIVE: begin
                    if (|ok_vec || |stop_vec) begin
                        tx_state <= cts_pkg::TX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_status <= '0;
            irq_en     <= cts_pkg::IRQ_EN_RESET;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= next_irq;
            irq_en     <= next_ien;
            o_irq      <= |(next_irq & next_ien);
        end
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    sequence s_fail_plain;
        active && i_tx_fail && !i_tx_done && !nar && !creq[cur];
    endsequence
    sequence s_cancel_running;
        active && creq[cur] && !i_tx_done && !i_tx_fail;
    endsequence

    cce_keeps_dms_a: assert property (
        (wr_ctrl && !i_pwdata[cts_pkg::CTRL_INIT_BIT] && !i_dbg_msg &&
         !i_bus_off) |=> $stable(debug_msg_state))
        else $error("config write moved debug state");
    dms_legal_code_a: assert property (debug_msg_state != 2'h3)
        else $error("debug state code illegal");
    dms_init_hold_a: assert property (
        (init && !dbg_reset) |=> $stable(debug_msg_state))
        else $error("debug state moved during init");
    dms_init_idle_a: assert property (
        wr_init1 |=> debug_msg_state == cts_pkg::DMS_IDLE && init)
        else $error("debug state not idle after init set");
    cancel_flags_a: assert property (
        |cdn_vec |=> ((cdone & $past(cdn_vec)) == $past(cdn_vec)) &&
                     ((pending & $past(cdn_vec)) == '0))
        else $error("cancel finish flags inconsistent");
    sent_on_ok_a: assert property (
        (active && i_tx_done) |=> sent[$past(cur)] && !pending[$past(cur)]
                                  && !cdone[$past(cur)])
        else $error("successful frame not marked sent");
    retry_now_a: assert property (
        s_fail_plain |=> o_tx_start && o_tx_buf == $past(cur) && active)
        else $error("failed frame not retried at once");
    no_false_cancel_a: assert property (
        s_cancel_running |=> !cdone[$past(cur)] && pending[$past(cur)])
        else $error("cancel confirmed while frame runs");
    apb_answer_a: assert property (
        (i_psel && !i_penable) ##1 (i_psel && i_penable) |=> o_pready)
        else $error("bus answer late");

    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    pready_pulse_a: assert property (
        o_pready |=> !o_pready)
        else $error("bus ready held over two cycles");
    slverr_unmapped_a: assert property (
        s_setup ##1 (acc && !mapped) |=> o_pslverr && o_pready)
        else $error("unmapped access not flagged");
    slverr_mapped_a: assert property (
        s_setup ##1 (acc && mapped) |=> !o_pslverr)
        else $error("mapped access flagged as error");
    rd_dms_data_a: assert property (
        s_setup ##1 (acc && !i_pwrite && hit_rxq) |=>
            o_prdata == {30'h0, $past(debug_msg_state)})
        else $error("read data does not show debug state");
    rd_holds_a: assert property (
        (o_pready && !i_pwrite) |=> $stable(o_prdata))
        else $error("read data moved after the answer");
    ctrl_write_a: assert property (
        wr_ctrl |=> cce == $past(i_pwdata[cts_pkg::CTRL_CCE_BIT]) &&
                    nar == $past(i_pwdata[cts_pkg::CTRL_NAR_BIT]))
        else $error("control write did not land");
    bus_off_init_a: assert property (
        (i_bus_off && !bus_off_q && !wr_ctrl) |=>
            init && debug_msg_state == cts_pkg::DMS_IDLE)
        else $error("bus-off did not idle debug state");
    sequence s_dbg_open;
        dbg_take && !dbg_reset && i_dbg_kind == cts_pkg::DBG_KIND_A;
    endsequence
    sequence s_dbg_second;
        dbg_take && !dbg_reset && debug_msg_state == cts_pkg::DMS_ONE &&
        i_dbg_kind == cts_pkg::DBG_KIND_B;
    endsequence
    dbg_first_a: assert property (
        s_dbg_open |=> debug_msg_state == cts_pkg::DMS_ONE)
        else $error("debug state did not open");
    dbg_second_a: assert property (
        s_dbg_second |=> debug_msg_state == cts_pkg::DMS_TWO)
        else $error("debug state did not advance");
    dbg_pair_a: assert property (
        s_dbg_open ##1 s_dbg_second |=> debug_msg_state == cts_pkg::DMS_TWO)
        else $error("debug message pair not tracked");
    dbg_drop_a: assert property (
        (dbg_take && !dbg_reset && i_dbg_kind != cts_pkg::DBG_KIND_A &&
         !(debug_msg_state == cts_pkg::DMS_ONE && i_dbg_kind == cts_pkg::DBG_KIND_B))
        |=> debug_msg_state == cts_pkg::DMS_IDLE)
        else $error("debug state not back to idle");
    irq_level_a: assert property (
        o_irq == |(irq_status & irq_en))
        else $error("interrupt line disagrees with status");
    irq_set_wins_a: assert property (
        (|ev_vec) |=> (irq_status & $past(ev_vec)) == $past(ev_vec))
        else $error("event lost against a clear");
    irq_clear_a: assert property (
        (|clr_only) |=> (irq_status & $past(clr_only)) == '0)
        else $error("status bit not cleared");
    start_pick_a: assert property (
        start |=> o_tx_start && active && pending[o_tx_buf] &&
                  o_tx_buf == cur)
        else $error("frame start on wrong buffer");
    tx_buf_stands_a: assert property (
        $changed(o_tx_buf) |-> o_tx_start)
        else $error("buffer index moved without a start");
    init_blocks_start_a: assert property (
        (init && !active) |=> !o_tx_start)
        else $error("frame started while in init");
    done_wins_a: assert property (
        (active && i_tx_done && i_tx_fail) |=> !o_tx_start && !active)
        else $error("fail beat a successful frame");
    no_retx_stop_a: assert property (
        (active && i_tx_fail && !i_tx_done && nar) |=>
            !o_tx_start && !active && !pending[$past(cur)] &&
            !sent[$past(cur)])
        else $error("retried with retransmission disabled");
    cancel_fail_a: assert property (
        (active && i_tx_fail && !i_tx_done && creq[cur]) |=>
            cdone[$past(cur)] && !pending[$past(cur)] && !active)
        else $error("cancelled failing frame not confirmed");
    add_clears_a: assert property (
        (|add_vec) |=> (pending & $past(add_vec)) == $past(add_vec) &&
                       (sent & $past(add_vec)) == '0 &&
                       (cdone & $past(add_vec)) == '0)
        else $error("add request left stale flags");
    cancel_not_sent_a: assert property (
        (|cdn_vec) |=> (sent & $past(cdn_vec)) == '0)
        else $error("cancelled buffer marked as sent");
    late_cancel_ok_a: assert property (
        (active && i_tx_done && creq[cur]) |=>
            sent[$past(cur)] && !cdone[$past(cur)])
        else $error("finished frame reported as cancelled");
endmodule : cts_can_tx_cancel_debug_state

/* include/cts_pkg.sv */
// Shared constants for the transmit cancel and debug state block
package cts_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CORE_CONTROL = 8'h00;
    localparam logic [7:0] OFS_RXQ1_STATUS  = 8'h04;
    localparam logic [7:0] OFS_TX_PENDING   = 8'h08;
    localparam logic [7:0] OFS_TX_ADD_REQ   = 8'h0C;
    localparam logic [7:0] OFS_TX_CANCEL    = 8'h10;
    localparam logic [7:0] OFS_TX_SENT      = 8'h14;
    localparam logic [7:0] OFS_TX_CDONE     = 8'h18;
    localparam logic [7:0] OFS_IRQ_STATUS   = 8'h1C;
    localparam logic [7:0] OFS_IRQ_CLEAR    = 8'h20;
    localparam logic [7:0] OFS_IRQ_ENABLE   = 8'h24;

    // Core control fields
    localparam int unsigned CTRL_INIT_BIT = 0;
    localparam int unsigned CTRL_CCE_BIT  = 1;
    localparam int unsigned CTRL_NAR_BIT  = 2;
    localparam logic        INIT_RESET    = 1'b1;
    localparam logic        CCE_RESET     = 1'b0;
    localparam logic        NAR_RESET     = 1'b0;

    // Debug message state field, low bits of the queue status register
    localparam int unsigned DMS_LSB  = 0;
    localparam logic [1:0]  DMS_IDLE = 2'h0;
    localparam logic [1:0]  DMS_ONE  = 2'h1;
    localparam logic [1:0]  DMS_TWO  = 2'h2;

    // Debug message kinds from the receive path
    localparam logic [1:0] DBG_KIND_A = 2'h0;
    localparam logic [1:0] DBG_KIND_B = 2'h1;
    localparam logic [1:0] DBG_KIND_C = 2'h2;

    // Interrupt status layout
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_SENT   = 0;
    localparam int unsigned IRQ_CANCEL = 1;
    localparam int unsigned IRQ_DBG    = 2;
    localparam logic [2:0]  IRQ_EN_RESET = 3'h0;

    typedef enum logic {TX_IDLE, TX_ACTIVE} cts_tx_state_t;
endpackage : cts_pkg

/* tb/cts_engine_model.sv */
// Protocol engine stand-in that ends each started frame
`timescale 1ns/1ns
module cts_engine_model (
    input  wire logic       i_core_clk,
    input  wire logic       i_start,
    input  wire logic [1:0] i_mode,
    input  wire logic [3:0] i_lat,
    output logic            o_done,
    output logic            o_fail
);
    // Mode 0 succeeds, 1 fails once then succeeds, 2 fails
    logic failed = 1'b0;
    initial begin
        o_done = 1'b0;
        o_fail = 1'b0;
    end
    always @(posedge i_core_clk) begin
        if (i_start === 1'b1) begin
            repeat (i_lat) @(posedge i_core_clk);
            if (i_mode == 2'h0 || (i_mode == 2'h1 && failed)) begin
                o_done <= 1'b1;
                failed = 1'b0;
            end else begin
                o_fail <= 1'b1;
                failed = (i_mode == 2'h1);
            end
            @(posedge i_core_clk);
            o_done <= 1'b0;
            o_fail <= 1'b0;
        end
    end
endmodule : cts_engine_model

/* tb/cts_can_tx_cancel_debug_state_tb.sv */
// Self-checking bench for the transmit cancel and debug state block
`timescale 1ns/1ns
module cts_can_tx_cancel_debug_state_tb;
    localparam logic [31:0] zero = 32'h0000_0000;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic        psel  = 1'b0;
    logic        pen   = 1'b0;
    logic        pwr   = 1'b0;
    logic        boff  = 1'b0;
    logic        dmsg  = 1'b0;
    logic [1:0]  dkind = 2'h0;
    logic [1:0]  mode  = 2'h0;
    logic [3:0]  lat   = 4'h1;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwd   = zero;
    logic [31:0] prd, rdata;
    logic        rdy, err, serr, done, fail, start, irq;
    logic [1:0]  tbuf;
    int          n_mismatch = 0, checks_done = 0, starts = 0;
    int          exp_dms = 0, exp_sent = 0, exp_cd = 0, b;
    always #25 clk = ~clk;
    always @(posedge clk) if (start === 1'b1) starts++;
    cts_can_tx_cancel_debug_state #(.NUM_BUF(4)) dut (
        .i_core_clk(clk), .i_reset(rst), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
        .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
        .o_pslverr(err), .i_tx_done(done), .i_tx_fail(fail),
        .i_bus_off(boff), .i_dbg_msg(dmsg), .i_dbg_kind(dkind),
        .o_tx_start(start), .o_tx_buf(tbuf), .o_irq(irq));
    cts_engine_model eng (.i_core_clk(clk), .i_start(start),
        .i_mode(mode), .i_lat(lat), .o_done(done), .o_fail(fail));
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel  <= 1'b1;
        pwr   <= w;
        paddr <= a;
        pwd   <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        rdata = prd;
        serr  = err;
        psel <= 1'b0;
        pen  <= 1'b0;
        if (rdy !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
    endtask : apb
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, zero);
        chk(rdata, e);
    endtask : rdc
    task automatic dbg(input logic [1:0] k);
        @(posedge clk);
        dmsg  <= 1'b1;
        dkind <= k;
        @(posedge clk);
        dmsg <= 1'b0;
        if (k == cts_pkg::DBG_KIND_A) exp_dms = 1;
        else if (k == cts_pkg::DBG_KIND_B && exp_dms == 1) exp_dms = 2;
        else exp_dms = 0;
        rdc(cts_pkg::OFS_RXQ1_STATUS, exp_dms);
    endtask : dbg
    task automatic send(input int bb, input logic [1:0] m, input int cdl);
        int i;
        mode <= m;
        apb(1'b1, cts_pkg::OFS_TX_ADD_REQ, 32'(1 << bb));
        if (cdl >= 0) begin
            repeat (cdl) @(posedge clk);
            apb(1'b1, cts_pkg::OFS_TX_CANCEL, 32'(1 << bb));
        end
        rdata = 32'h0000_0001;
        // Buffer is refilled only once its frame has ended
        for (i = 0; i < 40 && rdata != zero; i++) begin
            apb(1'b0, cts_pkg::OFS_TX_PENDING, zero);
        end
        if (rdata != zero) begin
            n_mismatch++;
            test_done();
        end
        rdc(cts_pkg::OFS_TX_SENT, exp_sent);
        rdc(cts_pkg::OFS_TX_CDONE, exp_cd);
        chk({30'h0, tbuf}, 32'(bb));
    endtask : send
    initial begin
        void'($urandom(68771));
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdc(cts_pkg::OFS_CORE_CONTROL, 32'h0000_0001);
        rdc(cts_pkg::OFS_RXQ1_STATUS, zero);
        apb(1'b0, 8'h30, zero);
        chk({31'h0, serr}, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, zero);
        dbg(cts_pkg::DBG_KIND_A);
        dbg(cts_pkg::DBG_KIND_B);
        dbg(cts_pkg::DBG_KIND_C);
        dbg(cts_pkg::DBG_KIND_A);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, 32'h0000_0002);
        rdc(cts_pkg::OFS_RXQ1_STATUS, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, 32'h0000_0003);
        rdc(cts_pkg::OFS_RXQ1_STATUS, zero);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, zero);
        dbg(cts_pkg::DBG_KIND_A);
        boff <= 1'b1;
        repeat (3) @(posedge clk);
        boff <= 1'b0;
        rdc(cts_pkg::OFS_RXQ1_STATUS, zero);
        rdc(cts_pkg::OFS_CORE_CONTROL, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_IRQ_CLEAR, 32'h0000_0007);
        apb(1'b1, cts_pkg::OFS_IRQ_ENABLE, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, zero);
        b = $urandom_range(3);
        lat <= 4'($urandom_range(8, 1));
        exp_sent = 1 << b;
        send(b, 2'h0, -1);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_IRQ_CLEAR, 32'h0000_0001);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, zero);
        starts = 0;
        lat <= 4'h3;
        exp_sent |= 2;
        send(1, 2'h1, -1);
        chk(starts, 2);
        lat <= 4'h8;
        exp_sent |= 4;
        send(2, 2'h1, 11);
        exp_sent &= ~8;
        exp_cd |= 8;
        send(3, 2'h2, 0);
        rdc(cts_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
        apb(1'b1, cts_pkg::OFS_IRQ_ENABLE, zero);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, zero);
        // Retries off: a failed frame is dropped, never restarted
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, 32'h0000_0004);
        starts = 0;
        exp_sent &= ~1;
        send(0, 2'h2, -1);
        chk(starts, 1);
        apb(1'b1, cts_pkg::OFS_CORE_CONTROL, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_TX_ADD_REQ, 32'h0000_0001);
        apb(1'b1, cts_pkg::OFS_TX_CANCEL, 32'h0000_0001);
        repeat (2) @(posedge clk);
        exp_sent &= ~1;
        exp_cd |= 1;
        rdc(cts_pkg::OFS_TX_PENDING, zero);
        rdc(cts_pkg::OFS_TX_CDONE, exp_cd);
        rdc(cts_pkg::OFS_TX_SENT, exp_sent);
        test_done();
    end
endmodule : cts_can_tx_cancel_debug_state_tb
